// [dv/dpsm_drive_model.sv]
// Behavioural drive model that answers the state machine from the far side.
`timescale 1ns/100ps
`default_nettype none
module dpsm_drive_model
  import dpsm_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        drvEnable,
  input  wire logic [15:0] drvSetpoint,
  input  wire logic        injFault,
  input  wire logic        localRun,
  output logic             drvReady,
  output logic             drvRunning,
  output logic             drvFault,
  output logic      [15:0] drvActVel
);
  logic [2:0] bootCnt;

  // The drive boots for a few cycles and runs one cycle after it is enabled or started locally.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bootCnt <= 3'h0;
      drvRunning <= 1'b0;
    end else begin
      bootCnt <= (bootCnt == 3'h7) ? bootCnt : bootCnt + 3'h1;
      drvRunning <= drvEnable || localRun;
    end
  end

  // A stopped drive reports zero speed, never the stale setpoint.
  assign drvReady = (bootCnt == 3'h7);
  assign drvFault = injFault;
  assign drvActVel = drvRunning ? drvSetpoint : 16'h0000;
endmodule
`default_nettype wire

// [dv/test_dpsm_core.sv]
// Self-checking testbench of the drive-profile state machine.
`timescale 1ns/100ps
`default_nettype none
module test_dpsm_core
  import dpsm_pkg::*;
;
  logic clk_sys = 1'b0, rstn = 1'b0, ctrlWordWr = 1'b0, targetVelWr = 1'b0, paramWr = 1'b0;
  logic mstPdWr = 1'b0, drvPdWr = 1'b0, remoteFieldbus = 1'b1, speedCtrlMode = 1'b1;
  logic stopFuncOnly = 1'b0, newFamily = 1'b1, injFault = 1'b0, localRun = 1'b0;
  logic [15:0] ctrlWord = 16'h0000, targetVel = 16'h0000, paramObj = 16'h0000;
  logic [15:0] statusWord, actualVel, drvSetpoint, drvActVel;
  logic [7:0]  paramSub = 8'h00, opModeDisplay;
  logic [31:0] paramData = 32'h0, mstPdWrData = 32'h0, drvPdWrData = 32'h0;
  logic [31:0] supportedModes, mstPdRdData, drvPdRdData, accDeltaSpeed;
  logic [31:0] velMinAmount, velMaxAmount, accDeltaTime, decDeltaSpeed, decDeltaTime;
  logic [4:0]  mstPdWrIdx = 5'h00, mstPdRdIdx = 5'h00, drvPdWrIdx = 5'h00, drvPdRdIdx = 5'h00;
  logic        drvReady, drvRunning, drvFault, drvEnable, drvStop, drvFaultReset;
  logic [1:0]  drvStopKind;
  int          n_fail = 0;
  int          cmp_count = 0;

  always #10 clk_sys = ~clk_sys;

  dpsm_core dpsm_core_i (.clk_sys, .rstn, .ctrlWordWr, .ctrlWord, .targetVelWr, .targetVel, .paramWr,
    .paramObj, .paramSub, .paramData, .statusWord, .actualVel, .opModeDisplay, .supportedModes, .mstPdWr,
    .mstPdWrIdx, .mstPdWrData, .mstPdRdIdx, .mstPdRdData, .drvReady, .drvRunning, .drvFault, .remoteFieldbus,
    .speedCtrlMode, .stopFuncOnly, .newFamily, .drvActVel, .drvEnable, .drvStop, .drvStopKind, .drvFaultReset,
    .drvSetpoint, .velMinAmount, .velMaxAmount, .accDeltaSpeed, .accDeltaTime, .decDeltaSpeed,
    .decDeltaTime, .drvPdWr, .drvPdWrIdx, .drvPdWrData, .drvPdRdIdx, .drvPdRdData);

  dpsm_drive_model dpsm_drive_model_i (.clk_sys, .rstn, .drvEnable, .drvSetpoint, .injFault, .localRun,
    .drvReady, .drvRunning, .drvFault, .drvActVel);

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // A command is held for one edge; the answer is read at the following falling edge.
  task automatic cmd(input logic [15:0] v, input logic [15:0] es);
    @(negedge clk_sys);
    ctrlWordWr = 1'b1;
    ctrlWord = v;
    @(negedge clk_sys);
    ctrlWordWr = 1'b0;
    chk("status", statusWord, es);
  endtask

  // Bounded poll at falling edges so one-cycle states are not missed.
  task automatic waitSt(input logic [15:0] es);
    for (int i = 0; i < 200; i++) begin
      if (statusWord === es) return;
      @(negedge clk_sys);
    end
    n_fail++;
    conclude();
  endtask

  // Writes one process-data item from the master side or the drive side.
  task automatic pdw(input bit m, input logic [4:0] i, input logic [31:0] d);
    @(negedge clk_sys);
    if (m) begin
      mstPdWr = 1'b1;
      mstPdWrIdx = i;
      mstPdWrData = d;
    end else begin
      drvPdWr = 1'b1;
      drvPdWrIdx = i;
      drvPdWrData = d;
    end
    @(negedge clk_sys);
    mstPdWr = 1'b0;
    drvPdWr = 1'b0;
  endtask

  // Writes one non-cyclic object; the value lands at the edge in between.
  task automatic prm(input logic [15:0] o, input logic [7:0] s, input logic [31:0] d);
    @(negedge clk_sys);
    paramWr = 1'b1;
    paramObj = o;
    paramSub = s;
    paramData = d;
    @(negedge clk_sys);
    paramWr = 1'b0;
  endtask

  task automatic settle();
    repeat (4) @(negedge clk_sys);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(negedge clk_sys);
    rstn = 1'b1;
    // The synchronised mode pin needs a few edges before bit 14 settles.
    repeat (6) @(negedge clk_sys);
    chk("status", statusWord, 16'h0000);
    chk("modes", supportedModes, 32'h8000_0002);
    chk("opmode", opModeDisplay, 8'h02);
    waitSt(16'h0040);
    cmd(16'h000F, 16'h0040);
    remoteFieldbus = 1'b0;
    settle();
    cmd(16'h0006, 16'h0040);
    remoteFieldbus = 1'b1;
    settle();
    cmd(16'h0006, 16'h0021);
    cmd(16'h000F, 16'h0023);
    @(negedge clk_sys);
    chk("status", statusWord, 16'h0027);
    chk("enable", drvEnable, 1'b1);
    targetVelWr = 1'b1;
    targetVel = 16'h1234;
    paramWr = 1'b1;
    paramObj = 16'h6048;
    paramSub = 8'h01;
    paramData = 32'hDEAD_BEEF;
    @(negedge clk_sys);
    targetVelWr = 1'b0;
    paramWr = 1'b0;
    chk("setpoint", drvSetpoint, 16'h1234);
    chk("accSpeed", accDeltaSpeed, 32'hDEAD_BEEF);
    prm(16'h6046, 8'h01, 32'h0000_0010);
    prm(16'h6046, 8'h02, 32'h0000_0020);
    prm(16'h6048, 8'h02, 32'h0000_0030);
    prm(16'h6049, 8'h01, 32'h0000_0040);
    prm(16'h6049, 8'h02, 32'h0000_0050);
    prm(16'h6046, 8'h03, 32'hFFFF_FFFF);
    chk("velMin", velMinAmount, 32'h0000_0010);
    chk("velMax", velMaxAmount, 32'h0000_0020);
    chk("accTime", accDeltaTime, 32'h0000_0030);
    chk("decSpeed", decDeltaSpeed, 32'h0000_0040);
    chk("decTime", decDeltaTime, 32'h0000_0050);
    settle();
    chk("actualVel", actualVel, 16'h1234);
    cmd(16'h0007, 16'h0023);
    chk("enable", drvEnable, 1'b0);
    cmd(16'h000F, 16'h0027);
    cmd(16'h0006, 16'h0021);
    chk("stop", {drvStop, drvStopKind}, 3'b100);
    cmd(16'h000F, 16'h0023);
    @(negedge clk_sys);
    cmd(16'h0002, 16'h0007);
    chk("stop", {drvStop, drvStopKind}, 3'b110);
    cmd(16'h0000, 16'h0040);
    // Disable voltage from operation, with and without the stop-function fallback.
    for (int k = 0; k < 2; k++) begin
      stopFuncOnly = k[0];
      settle();
      cmd(16'h0006, 16'h0021);
      cmd(16'h000F, 16'h0023);
      @(negedge clk_sys);
      cmd(16'h0000, 16'h0040);
      chk("stop", {drvStop, drvStopKind}, k[0] ? 3'b111 : 3'b101);
    end
    injFault = 1'b1;
    waitSt(16'h000F);
    chk("stop", {drvStop, drvStopKind}, 3'b111);
    @(negedge clk_sys);
    chk("status", statusWord, 16'h0008);
    cmd(16'h0080, 16'h0008);
    chk("faultRst", drvFaultReset, 1'b1);
    injFault = 1'b0;
    settle();
    cmd(16'h0080, 16'h0040);
    chk("faultRst", drvFaultReset, 1'b1);
    // A locally started drive pulls the state along without the master.
    cmd(16'h0006, 16'h0021);
    remoteFieldbus = 1'b0;
    localRun = 1'b1;
    waitSt(16'h0027);
    localRun = 1'b0;
    remoteFieldbus = 1'b1;
    settle();
    cmd(16'h0000, 16'h0040);
    speedCtrlMode = 1'b0;
    settle();
    chk("status", statusWord, 16'h4040);
    pdw(1'b1, 5'h03, 32'h1234_5678);
    pdw(1'b0, 5'h02, 32'hCAFE_0001);
    pdw(1'b1, 5'h10, 32'hAABB_CCDD);
    newFamily = 1'b0;
    settle();
    pdw(1'b1, 5'h10, 32'h1111_1111);
    drvPdRdIdx = 5'h03;
    mstPdRdIdx = 5'h02;
    @(negedge clk_sys);
    chk("pdIn", drvPdRdData, 32'h0000_5678);
    chk("pdOut", mstPdRdData, 32'h0000_0001);
    drvPdRdIdx = 5'h10;
    @(negedge clk_sys);
    chk("pdWide", drvPdRdData, 32'hAABB_CCDD);
    conclude();
  end

  // Cuts a hang short well inside the cycle budget.
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire

// [src/dpsm_cmd_dec.sv]
// Control word command decoder.
`timescale 1ns/100ps
`default_nettype none
module dpsm_cmd_dec
  import dpsm_pkg::*;
(
  input  wire logic [15:0] ctrlWord,
  output var dpsm_cmd_e    cmd
);

  // ----------------------------------------------------------------
  // Decode, highest priority first
  // ----------------------------------------------------------------
  // Fault reset masks every other bit, then voltage, then quick stop.
  always_comb begin
    if (ctrlWord[CW_FAULT_RST]) begin
      cmd = CMD_FAULT_RST;
    end else if (!ctrlWord[CW_VOLTAGE]) begin
      cmd = CMD_DIS_VOLT;
    end else if (!ctrlWord[CW_QSTOP_N]) begin
      cmd = CMD_QSTOP;
    end else if (!ctrlWord[CW_SWITCH_ON]) begin
      cmd = CMD_SHUTDOWN;
    end else if (ctrlWord[CW_ENABLE_OP]) begin
      cmd = CMD_ENABLE_OP;
    end else begin
      cmd = CMD_SWITCH_ON;
    end
  end

endmodule
`default_nettype wire

// [src/dpsm_core.sv]
// Drive-profile power state machine in velocity mode.
`timescale 1ns/100ps
`default_nettype none
module dpsm_core
  import dpsm_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             ctrlWordWr,
  input  wire logic [15:0]      ctrlWord,
  input  wire logic             targetVelWr,
  input  wire logic [15:0]      targetVel,
  input  wire logic             paramWr,
  input  wire logic [15:0]      paramObj,
  input  wire logic [7:0]       paramSub,
  input  wire logic [31:0]      paramData,
  output logic      [15:0]      statusWord,
  output logic      [15:0]      actualVel,
  output logic      [7:0]       opModeDisplay,
  output logic      [31:0]      supportedModes,
  input  wire logic             mstPdWr,
  input  wire logic [PD_AW-1:0] mstPdWrIdx,
  input  wire logic [PD_DW-1:0] mstPdWrData,
  input  wire logic [PD_AW-1:0] mstPdRdIdx,
  output logic      [PD_DW-1:0] mstPdRdData,
  input  wire logic             drvReady,
  input  wire logic             drvRunning,
  input  wire logic             drvFault,
  input  wire logic             remoteFieldbus,
  input  wire logic             speedCtrlMode,
  input  wire logic             stopFuncOnly,
  input  wire logic             newFamily,
  input  wire logic [15:0]      drvActVel,
  output logic                  drvEnable,
  output logic                  drvStop,
  output logic      [1:0]       drvStopKind,
  output logic                  drvFaultReset,
  output logic      [15:0]      drvSetpoint,
  output logic      [31:0]      velMinAmount,
  output logic      [31:0]      velMaxAmount,
  output logic      [31:0]      accDeltaSpeed,
  output logic      [31:0]      accDeltaTime,
  output logic      [31:0]      decDeltaSpeed,
  output logic      [31:0]      decDeltaTime,
  input  wire logic             drvPdWr,
  input  wire logic [PD_AW-1:0] drvPdWrIdx,
  input  wire logic [PD_DW-1:0] drvPdWrData,
  input  wire logic [PD_AW-1:0] drvPdRdIdx,
  output logic      [PD_DW-1:0] drvPdRdData
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rstSync_ff;
  logic       rstnInt;

  // Assertion is immediate, release is clean through two stages.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstSync_ff <= 2'b00;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rstnInt = rstSync_ff[1];

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [6:0]  pinA;
    logic [6:0]  pinB;
    logic [15:0] velA;
    logic [15:0] velB;
    dpsm_state_e state;
    logic [7:0]  initCnt;
    logic        pendEnable;
    logic        enable;
    logic        stop;
    dpsm_stop_e  stopKind;
    logic        faultRst;
    logic [15:0] status;
    logic [15:0] setpoint;
    logic [31:0] velMin;
    logic [31:0] velMax;
    logic [31:0] accDs;
    logic [31:0] accDt;
    logic [31:0] decDs;
    logic [31:0] decDt;
  } dpsm_core_s;

  localparam dpsm_core_s RST_STATE = '{
    pinA: 7'h00, pinB: 7'h00, velA: RST_WORD, velB: RST_WORD,
    state: ST_NOT_READY, initCnt: INIT_CYCLES, pendEnable: 1'b0,
    enable: 1'b0, stop: 1'b0, stopKind: STOP_RAMP, faultRst: 1'b0,
    status: RST_WORD, setpoint: RST_WORD, velMin: RST_PARAM,
    velMax: RST_PARAM, accDs: RST_PARAM, accDt: RST_PARAM,
    decDs: RST_PARAM, decDt: RST_PARAM};

  dpsm_core_s q_ff;
  dpsm_core_s nxt_q;

  // Synchronised drive lines, read only from the second stage.
  logic      fReady;
  logic      fRunning;
  logic      fFault;
  logic      fFieldbus;
  logic      fSpeedMode;
  logic      fStopOnly;
  logic      fNewFamily;
  dpsm_cmd_e cmd;
  logic      cmdOk;

  assign {fNewFamily, fStopOnly, fSpeedMode, fFieldbus,
          fFault, fRunning, fReady} = q_ff.pinB;

  // ----------------------------------------------------------------
  // Command decode and process data
  // ----------------------------------------------------------------
  dpsm_cmd_dec uDec (
    .ctrlWord (ctrlWord),
    .cmd      (cmd)
  );

  // Commands from the master are ignored under any other control place.
  assign cmdOk = ctrlWordWr && fFieldbus;

  // The upper sixteen items take writes only on the newer family; narrow
  // items keep just their low half so stale upper bits never leak.
  function automatic logic pd_ok(input logic [PD_AW-1:0] idx,
                                 input logic             wide);
    pd_ok = !idx[PD_AW-1] || wide;
  endfunction

  function automatic logic [PD_DW-1:0] pd_fit(input logic [PD_AW-1:0] idx,
                                              input logic [PD_DW-1:0] d);
    pd_fit = idx[PD_AW-1] ? d : {{(PD_DW-PD_NARROW){1'b0}}, d[PD_NARROW-1:0]};
  endfunction

  dpsm_pd_mem uPdIn (
    .clk_sys (clk_sys),
    .wrEn    (mstPdWr && pd_ok(mstPdWrIdx, fNewFamily)),
    .wrIdx   (mstPdWrIdx),
    .wrData  (pd_fit(mstPdWrIdx, mstPdWrData)),
    .rdIdx   (drvPdRdIdx),
    .rdData  (drvPdRdData)
  );

  dpsm_pd_mem uPdOut (
    .clk_sys (clk_sys),
    .wrEn    (drvPdWr && pd_ok(drvPdWrIdx, fNewFamily)),
    .wrIdx   (drvPdWrIdx),
    .wrData  (pd_fit(drvPdWrIdx, drvPdWrData)),
    .rdIdx   (mstPdRdIdx),
    .rdData  (mstPdRdData)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic dpsm_stop_e stop_sel(input dpsm_stop_e k,
                                          input logic       only);
    stop_sel = only ? STOP_FUNC : k;
  endfunction

  function automatic logic [6:0] state_code(input dpsm_state_e s);
    case (s)
      ST_NOT_READY:  state_code = SW_NOT_READY;
      ST_SW_ON_DIS:  state_code = SW_SW_ON_DIS;
      ST_READY:      state_code = SW_READY;
      ST_SWITCHED:   state_code = SW_SWITCHED;
      ST_OP_ENABLED: state_code = SW_OP_ENABLED;
      ST_QUICK_STOP: state_code = SW_QUICK_STOP;
      ST_FAULT_REAC: state_code = SW_FAULT_REAC;
      ST_FAULT:      state_code = SW_FAULT;
      default:       state_code = SW_NOT_READY;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // A fault outranks every command; tracking of a locally run drive
  // only applies when the master does not own the control place.
  always_comb begin
    nxt_q          = q_ff;
    nxt_q.pinA     = {newFamily, stopFuncOnly, speedCtrlMode, remoteFieldbus,
                      drvFault, drvRunning, drvReady};
    nxt_q.pinB     = q_ff.pinA;
    nxt_q.velA     = drvActVel;
    nxt_q.velB     = q_ff.velA;
    nxt_q.stop     = 1'b0;
    nxt_q.faultRst = 1'b0;
    if (targetVelWr) begin
      nxt_q.setpoint = targetVel;
    end
    if (paramWr) begin
      case ({paramObj, paramSub})
        {OBJ_VEL_LIMIT, SUB_ONE}: nxt_q.velMin = paramData;
        {OBJ_VEL_LIMIT, SUB_TWO}: nxt_q.velMax = paramData;
        {OBJ_ACCEL, SUB_ONE}:     nxt_q.accDs = paramData;
        {OBJ_ACCEL, SUB_TWO}:     nxt_q.accDt = paramData;
        {OBJ_DECEL, SUB_ONE}:     nxt_q.decDs = paramData;
        {OBJ_DECEL, SUB_TWO}:     nxt_q.decDt = paramData;
        default:                  nxt_q.velMin = q_ff.velMin;
      endcase
    end
    if (fFault && q_ff.state != ST_NOT_READY && q_ff.state != ST_FAULT_REAC
        && q_ff.state != ST_FAULT) begin
      nxt_q.state      = ST_FAULT_REAC;
      nxt_q.pendEnable = 1'b0;
      nxt_q.stop       = 1'b1;
      nxt_q.stopKind   = STOP_FUNC;
    end else begin
      case (q_ff.state)
        ST_NOT_READY: begin
          if (q_ff.initCnt != 8'h00) begin
            nxt_q.initCnt = q_ff.initCnt - 8'h01;
          end else if (fReady) begin
            nxt_q.state = ST_SW_ON_DIS;
          end
        end
        ST_SW_ON_DIS: begin
          if (cmdOk && cmd == CMD_SHUTDOWN) begin
            nxt_q.state = ST_READY;
          end
        end
        ST_READY: begin
          if (!fFieldbus && fRunning) begin
            nxt_q.state = ST_OP_ENABLED;
          end else if (cmdOk && cmd == CMD_SWITCH_ON) begin
            nxt_q.state = ST_SWITCHED;
          end else if (cmdOk && cmd == CMD_ENABLE_OP) begin
            nxt_q.state      = ST_SWITCHED;
            nxt_q.pendEnable = 1'b1;
          end else if (cmdOk && (cmd == CMD_DIS_VOLT || cmd == CMD_QSTOP)) begin
            nxt_q.state = ST_SW_ON_DIS;
          end
        end
        ST_SWITCHED: begin
          if (q_ff.pendEnable || (!fFieldbus && fRunning)
              || (cmdOk && cmd == CMD_ENABLE_OP)) begin
            nxt_q.state      = ST_OP_ENABLED;
            nxt_q.pendEnable = 1'b0;
          end else if (cmdOk && cmd == CMD_SHUTDOWN) begin
            nxt_q.state = ST_READY;
          end else if (cmdOk && (cmd == CMD_DIS_VOLT || cmd == CMD_QSTOP)) begin
            nxt_q.state = ST_SW_ON_DIS;
          end
        end
        ST_OP_ENABLED: begin
          if (!fFieldbus && !fRunning) begin
            nxt_q.state = ST_SWITCHED;
          end else if (cmdOk && cmd == CMD_SWITCH_ON) begin
            nxt_q.state = ST_SWITCHED;
          end else if (cmdOk && cmd == CMD_SHUTDOWN) begin
            nxt_q.state    = ST_READY;
            nxt_q.stop     = 1'b1;
            nxt_q.stopKind = stop_sel(STOP_RAMP, fStopOnly);
          end else if (cmdOk && cmd == CMD_DIS_VOLT) begin
            nxt_q.state    = ST_SW_ON_DIS;
            nxt_q.stop     = 1'b1;
            nxt_q.stopKind = stop_sel(STOP_COAST, fStopOnly);
          end else if (cmdOk && cmd == CMD_QSTOP) begin
            nxt_q.state    = ST_QUICK_STOP;
            nxt_q.stop     = 1'b1;
            nxt_q.stopKind = stop_sel(STOP_QUICK, fStopOnly);
          end
        end
        ST_QUICK_STOP: begin
          if (cmdOk && cmd == CMD_DIS_VOLT) begin
            nxt_q.state = ST_SW_ON_DIS;
          end else if (cmdOk && cmd == CMD_ENABLE_OP) begin
            nxt_q.state = ST_OP_ENABLED;
          end
        end
        ST_FAULT_REAC: begin
          nxt_q.state = ST_FAULT;
        end
        ST_FAULT: begin
          if (cmdOk && cmd == CMD_FAULT_RST) begin
            nxt_q.faultRst = 1'b1;
            if (!fFault) begin
              nxt_q.state = ST_SW_ON_DIS;
            end
          end
        end
        default: begin
          nxt_q.state = ST_NOT_READY;
        end
      endcase
    end
    // Any other state pattern falls to the default branch and returns to ST_NOT_READY.
    nxt_q.enable = (nxt_q.state == ST_OP_ENABLED);
    nxt_q.status = {1'b0, !fSpeedMode, 7'h00, state_code(nxt_q.state)};
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      q_ff <= RST_STATE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign statusWord     = q_ff.status;
  assign actualVel      = q_ff.velB;
  assign opModeDisplay  = MODE_VELOCITY;
  assign supportedModes = SUPPORTED_MODES;
  assign drvEnable      = q_ff.enable;
  assign drvStop        = q_ff.stop;
  assign drvStopKind    = q_ff.stopKind;
  assign drvFaultReset  = q_ff.faultRst;
  assign drvSetpoint    = q_ff.setpoint;
  assign velMinAmount   = q_ff.velMin;
  assign velMaxAmount   = q_ff.velMax;
  assign accDeltaSpeed  = q_ff.accDs;
  assign accDeltaTime   = q_ff.accDt;
  assign decDeltaSpeed  = q_ff.decDs;
  assign decDeltaTime   = q_ff.decDt;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstnInt);

  sequence s_fault_seen;
    fFault && q_ff.state inside {ST_SW_ON_DIS, ST_READY, ST_SWITCHED,
                                 ST_OP_ENABLED, ST_QUICK_STOP};
  endsequence
  sequence s_reaction_then_fault;
    q_ff.state == ST_FAULT_REAC && drvStop && drvStopKind == STOP_FUNC
    ##1 q_ff.state == ST_FAULT;
  endsequence
  sequence s_auto_enable;
    q_ff.state == ST_SWITCHED ##1 q_ff.state == ST_OP_ENABLED && drvEnable;
  endsequence

  fault_entry_a: assert property (s_fault_seen |=> s_reaction_then_fault)
    else $error("fault did not pass through reaction into fault");
  fault_clear_a: assert property (q_ff.state == ST_FAULT && cmdOk && cmd == CMD_FAULT_RST
    && !fFault |=> q_ff.state == ST_SW_ON_DIS && drvFaultReset)
    else $error("fault reset did not clear the fault state");
  fault_hold_a: assert property (q_ff.state == ST_FAULT && fFault |=> q_ff.state == ST_FAULT)
    else $error("fault state left while drive fault present");
  auto_enable_a: assert property (q_ff.state == ST_READY && cmdOk && cmd == CMD_ENABLE_OP
    && !fFault |=> s_auto_enable)
    else $error("switch on plus enable did not reach operation");
  remote_lock_a: assert property (q_ff.state == ST_SW_ON_DIS && !fFieldbus && !fFault
    |=> q_ff.state == ST_SW_ON_DIS)
    else $error("state changed without fieldbus control place");
  fault_code_a: assert property (q_ff.state == ST_FAULT |-> statusWord[6:0] == 7'h08)
    else $error("fault state code wrong");
  op_code_a: assert property ($rose(drvEnable) |-> statusWord[6:0] == 7'h27)
    else $error("operation enabled code wrong");
  wrong_mode_a: assert property (!fSpeedMode |=> statusWord[SW_WRONG_MODE])
    else $error("mode flag not set outside speed control");
  stop_fallback_a: assert property (drvStop && $past(fStopOnly) |-> drvStopKind == STOP_FUNC)
    else $error("stop kind ignored stop function fallback");
  coast_stop_a: assert property (q_ff.state == ST_OP_ENABLED && cmdOk && cmd == CMD_DIS_VOLT
    && !fFault && !fStopOnly |=> drvStop && drvStopKind == STOP_COAST && !drvEnable)
    else $error("disable voltage did not coast the drive");
  init_wait_a: assert property (q_ff.state == ST_NOT_READY && q_ff.initCnt != 8'h00
    |=> q_ff.state == ST_NOT_READY)
    else $error("self-initialisation cut short");

endmodule
`default_nettype wire

// [src/dpsm_pd_mem.sv]
// Process-data word store with one write port and a registered read port.
`timescale 1ns/100ps
`default_nettype none
module dpsm_pd_mem
  import dpsm_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             wrEn,
  input  wire logic [PD_AW-1:0] wrIdx,
  input  wire logic [PD_DW-1:0] wrData,
  input  wire logic [PD_AW-1:0] rdIdx,
  output logic      [PD_DW-1:0] rdData
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [PD_DW-1:0] mem [2**PD_AW];

  // Contents are not reset; software refreshes them cyclically anyway.
  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
    rdData <= mem[rdIdx];
  end

endmodule
`default_nettype wire

// [src/dpsm_pkg.sv]
// Shared types and constants of the drive-profile state machine.
package dpsm_pkg;

  // ----------------------------------------------------------------
  // Power-drive states and decoded commands
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_NOT_READY  = 3'b000,
    ST_SW_ON_DIS  = 3'b001,
    ST_READY      = 3'b010,
    ST_SWITCHED   = 3'b011,
    ST_OP_ENABLED = 3'b100,
    ST_QUICK_STOP = 3'b101,
    ST_FAULT_REAC = 3'b110,
    ST_FAULT      = 3'b111
  } dpsm_state_e;

  typedef enum logic [2:0] {
    CMD_NONE      = 3'b000,
    CMD_SHUTDOWN  = 3'b001,
    CMD_SWITCH_ON = 3'b010,
    CMD_ENABLE_OP = 3'b011,
    CMD_DIS_VOLT  = 3'b100,
    CMD_QSTOP     = 3'b101,
    CMD_FAULT_RST = 3'b110
  } dpsm_cmd_e;

  typedef enum logic [1:0] {
    STOP_RAMP  = 2'b00,
    STOP_COAST = 2'b01,
    STOP_QUICK = 2'b10,
    STOP_FUNC  = 2'b11
  } dpsm_stop_e;

  // ----------------------------------------------------------------
  // Object indices and sub-indices
  // ----------------------------------------------------------------
  localparam logic [15:0] OBJ_CTRL_WORD  = 16'h6040;
  localparam logic [15:0] OBJ_STAT_WORD  = 16'h6041;
  localparam logic [15:0] OBJ_TARGET_VEL = 16'h6042;
  localparam logic [15:0] OBJ_ACTUAL_VEL = 16'h6044;
  localparam logic [15:0] OBJ_VEL_LIMIT  = 16'h6046;
  localparam logic [15:0] OBJ_ACCEL      = 16'h6048;
  localparam logic [15:0] OBJ_DECEL      = 16'h6049;
  localparam logic [7:0]  SUB_ONE        = 8'h01;
  localparam logic [7:0]  SUB_TWO        = 8'h02;

  // ----------------------------------------------------------------
  // Field positions, codes and reset values
  // ----------------------------------------------------------------
  localparam int          CW_FAULT_RST   = 7;
  localparam int          CW_ENABLE_OP   = 3;
  localparam int          CW_QSTOP_N     = 2;
  localparam int          CW_VOLTAGE     = 1;
  localparam int          CW_SWITCH_ON   = 0;
  localparam int          SW_WRONG_MODE  = 14;
  localparam logic [6:0]  SW_NOT_READY   = 7'h00;
  localparam logic [6:0]  SW_SW_ON_DIS   = 7'h40;
  localparam logic [6:0]  SW_READY       = 7'h21;
  localparam logic [6:0]  SW_SWITCHED    = 7'h23;
  localparam logic [6:0]  SW_OP_ENABLED  = 7'h27;
  localparam logic [6:0]  SW_QUICK_STOP  = 7'h07;
  localparam logic [6:0]  SW_FAULT_REAC  = 7'h0F;
  localparam logic [6:0]  SW_FAULT       = 7'h08;
  localparam logic [31:0] SUPPORTED_MODES = 32'h8000_0002;
  localparam logic [7:0]  MODE_VELOCITY  = 8'h02;
  localparam logic [31:0] RST_PARAM      = 32'h0000_0000;
  localparam logic [15:0] RST_WORD       = 16'h0000;
  localparam logic [7:0]  INIT_CYCLES    = 8'h10;
  localparam int          PD_AW          = 5;
  localparam int          PD_DW          = 32;
  localparam int          PD_NARROW      = 16;

endpackage
